// ==== cmp_b_pkg.sv ====
/*
  constants for the comparator b event and control block: register offsets,
  field positions, reset values, mode codes and timing counts.
  assumes an apb register bus with 32-bit data and word-aligned registers.
*/
`default_nettype none
package cmp_b_pkg;
  // printed offsets are not word multiples: kept as indices, byte address is index*4
  localparam logic [7:0]  IDX_REF_CLK_SEL  = 8'haf;
  localparam logic [7:0]  IDX_CTRL_STATUS  = 8'hb0;
  localparam logic [7:0]  IDX_IRQ_ENABLE   = 8'hb1;
  localparam logic [7:0]  IDX_IRQ_STATUS   = 8'hb2;
  localparam logic [7:0]  IDX_IRQ_MASK     = 8'hb3;
  localparam logic [11:0] ADDR_REF_CLK_SEL = {2'h0, IDX_REF_CLK_SEL, 2'h0};
  localparam logic [11:0] ADDR_CTRL_STATUS = {2'h0, IDX_CTRL_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_ENABLE  = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS  = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};

  localparam logic [7:0] REF_RESET  = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'hc0;
  localparam logic [7:0] IE_RESET   = 8'h00;

  // control register fields, then the interrupt enable register bit
  localparam int POS_SEL_LSB  = 6;
  localparam int CONNECT_BIT  = 5;
  localparam int FLAG_BIT     = 4;
  localparam int ENABLE_BIT   = 3;
  localparam int MODE_LSB     = 0;
  localparam int IE_CMP_BIT   = 6;
  // reference register fields
  localparam int B_CLK_LSB    = 6;
  localparam int B_NEG_LSB    = 4;
  localparam int A_CLK_LSB    = 2;
  localparam int A_NEG_LSB    = 0;

  // sticky status bits
  localparam int ST_EVENT     = 0;
  localparam int ST_DEB_MISS  = 1;
  localparam int ST_WIDTH     = 2;

  localparam int DEB_OVF_WAIT  = 2;
  localparam int TIMER_SAMPLES = 4;

  typedef enum logic [2:0] {
    MODE_LOW        = 3'h0,
    MODE_RISE       = 3'h1,
    MODE_DEB_TOGGLE = 3'h2,
    MODE_DEB_RISE   = 3'h3,
    MODE_FALL       = 3'h4,
    MODE_TOGGLE     = 3'h5,
    MODE_DEB_FALL   = 3'h6,
    MODE_HIGH       = 3'h7
  } irq_mode_t;

  typedef enum logic [1:0] {
    CLK_SYS  = 2'h0,
    CLK_TMR0 = 2'h1,
    CLK_TMR1 = 2'h2,
    CLK_TMR2 = 2'h3
  } clk_sel_t;

  typedef enum logic [1:0] {
    NEG_PIN  = 2'h0,
    NEG_LOW  = 2'h1,
    NEG_NOM  = 2'h2,
    NEG_HIGH = 2'h3
  } neg_sel_t;
endpackage
`default_nettype wire

// ==== comparator_event_control.sv ====
/*
  comparator b control and event logic, shared reference/clock select register,
  apb slave and sticky interrupt status.
  assumes the analog comparator outputs and timer overflow pulses are synchronous
  to clk_sys, overflows being one-cycle pulses.
*/
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - connect bit high routes selected pins to comparator b, low isolates them
// - 2-bit positive select picks one of four inputs; clear connect first
// - event flag sets when sampled output meets mode condition; software clears
// - flag interrupt reaches the processor only while enable bit 6 set
// - enable low forces comparator output low and blocks new events
// - enable high puts the four analog port pins into input-only mode
// - mode codes: low, rise, deb toggle, deb rise, fall, toggle, deb fall, high
// - debounced modes time their delay from timer 1 overflows
// - reference register resets to zero; fields b clk, b neg, a clk, a neg
// - b negative select: analog pin or one of three internal references
// - a negative select: other analog pin or the same three references
// - debounce waits two timer 1 overflows, resamples, sets on match
// - with timer sampling an edge needs four agreeing samples
module comparator_event_control
  import cmp_b_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  cmpBRaw,
  input  wire logic                  tmr0Ovf,
  input  wire logic                  tmr1Ovf,
  input  wire logic                  tmr2Ovf,
  output logic                       cmpBOut,
  output logic                       cmpBPinConnect,
  output logic      [1:0]            cmpBPositiveSelect,
  output logic      [1:0]            cmpBNegativeSelect,
  output logic      [1:0]            cmpANegativeSelect,
  output logic      [1:0]            cmpAClockSelect,
  output logic                       analogPinsInputOnly,
  output logic                       cmpBIrq,
  output logic                       irq
);
  import cmp_b_pkg::*;

  typedef enum {DB_IDLE, DB_WAIT} deb_state_t;

  function automatic logic isDebMode(input logic [2:0] m);
    isDebMode = (m == MODE_DEB_TOGGLE) || (m == MODE_DEB_RISE) || (m == MODE_DEB_FALL);
  endfunction

  // register file
  logic [7:0]          refSel_r;
  logic [7:0]          refSel_nxt;
  logic [7:0]          ctrl_r;
  logic [7:0]          ctrl_nxt;
  logic [7:0]          ieReg_r;
  logic [7:0]          ieReg_nxt;
  logic [ST_WIDTH-1:0] status_r;
  logic [ST_WIDTH-1:0] status_nxt;
  logic [ST_WIDTH-1:0] mask_r;
  logic [ST_WIDTH-1:0] mask_nxt;
  logic [31:0]         prdata_nxt;
  logic                pready_nxt;
  logic                pslverr_nxt;
  // sampling and debounce state
  logic                sample_r;
  logic                sample_nxt;
  logic [2:0]          agree_r;
  logic [2:0]          agree_nxt;
  logic                stable_r;
  logic                stable_nxt;
  deb_state_t          dbState_r;
  deb_state_t          dbState_nxt;
  logic [1:0]          ovfCnt_r;
  logic [1:0]          ovfCnt_nxt;
  logic                expect_r;
  logic                expect_nxt;
  logic                cmpOut_r;
  logic                cmpOut_nxt;
  logic                irqOut_r;
  logic                irqOut_nxt;
  logic                cmpIrq_r;
  logic                cmpIrq_nxt;

  logic                enable;
  logic                sampleTick;
  logic                timerClocked;
  logic                rise;
  logic                fall;
  logic                eventHit;
  logic                debMiss;
  logic                accessW;
  logic                accessR;
  logic [2:0]          mode;
  logic [1:0]          bClk;
  logic [ADDR_WIDTH-1:0] addrW;

  assign mode    = ctrl_r[MODE_LSB +: 3];
  assign enable  = ctrl_r[ENABLE_BIT];
  assign bClk    = refSel_r[B_CLK_LSB +: 2];
  assign accessW = psel && penable && pwrite;
  assign accessR = psel && penable && !pwrite;
  assign addrW   = {paddr[ADDR_WIDTH-1:2], 2'h0};

  // sampling clock select; timers arrive as enable pulses
  always_comb begin
    case (clk_sel_t'(bClk))
      CLK_SYS:  sampleTick = 1'b1;
      CLK_TMR0: sampleTick = tmr0Ovf;
      CLK_TMR1: sampleTick = tmr1Ovf;
      CLK_TMR2: sampleTick = tmr2Ovf;
      default:  sampleTick = 1'b1;
    endcase
    timerClocked = (bClk != CLK_SYS);
  end

  // sampling, glitch filter and debouncer
  always_comb begin
    cmpOut_nxt  = enable ? cmpBRaw : 1'b0;
    sample_nxt  = sample_r;
    agree_nxt   = agree_r;
    stable_nxt  = stable_r;
    dbState_nxt = dbState_r;
    ovfCnt_nxt  = ovfCnt_r;
    expect_nxt  = expect_r;
    rise        = 1'b0;
    fall        = 1'b0;
    eventHit    = 1'b0;
    debMiss     = 1'b0;
    if (sampleTick) begin
      sample_nxt = cmpOut_r;
      if (!timerClocked) begin
        stable_nxt = cmpOut_r;
        agree_nxt  = 3'h0;
      end else if (cmpOut_r == stable_r) begin
        agree_nxt = 3'h0;
      end else if (agree_r == 3'(TIMER_SAMPLES - 1)) begin
        stable_nxt = cmpOut_r; // change held four samples
        agree_nxt  = 3'h0;
      end else begin
        agree_nxt = agree_r + 3'h1;
      end
      rise = (stable_nxt && !stable_r);
      fall = (!stable_nxt && stable_r);
    end
    case (irq_mode_t'(mode))
      MODE_LOW:    eventHit = sampleTick && !stable_nxt;
      MODE_HIGH:   eventHit = sampleTick && stable_nxt;
      MODE_RISE:   eventHit = rise;
      MODE_FALL:   eventHit = fall;
      MODE_TOGGLE: eventHit = rise || fall;
      default:     eventHit = 1'b0;
    endcase
    // debounce counts timer 1 overflows regardless of the sample clock
    case (dbState_r)
      DB_IDLE: begin
        ovfCnt_nxt = 2'h0;
        if (isDebMode(mode) && (((mode != MODE_DEB_FALL) && rise) || ((mode != MODE_DEB_RISE) && fall))) begin
          expect_nxt  = rise;
          dbState_nxt = DB_WAIT;
        end
      end
      DB_WAIT: begin
        if (!isDebMode(mode) || !enable) begin
          dbState_nxt = DB_IDLE;
        end else if (tmr1Ovf) begin
          if (ovfCnt_r == 2'(DEB_OVF_WAIT - 1)) begin
            dbState_nxt = DB_IDLE; // resample after two overflows
            if (cmpOut_r == expect_r) begin
              eventHit = 1'b1;
            end else begin
              debMiss = 1'b1;
            end
          end else begin
            ovfCnt_nxt = ovfCnt_r + 2'h1;
          end
        end
      end
      default: dbState_nxt = DB_IDLE;
    endcase
    eventHit = eventHit && enable;
  end

  // apb register file and sticky status
  always_comb begin
    refSel_nxt  = refSel_r;
    ctrl_nxt    = ctrl_r;
    ieReg_nxt   = ieReg_r;
    mask_nxt    = mask_r;
    status_nxt  = status_r;
    prdata_nxt  = 32'h0;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    // one wait state: answer the cycle after the access phase starts
    if (psel && penable && !pready) begin
      pready_nxt = 1'b1;
      case (addrW)
        ADDR_REF_CLK_SEL: prdata_nxt = {24'h0, refSel_r};
        ADDR_CTRL_STATUS: prdata_nxt = {24'h0, ctrl_r};
        ADDR_IRQ_ENABLE:  prdata_nxt = {24'h0, ieReg_r};
        ADDR_IRQ_STATUS:  prdata_nxt = {30'h0, status_r};
        ADDR_IRQ_MASK:    prdata_nxt = {30'h0, mask_r};
        default:          pslverr_nxt = 1'b1;
      endcase
    end
    if (accessW && pready) begin
      case (addrW)
        ADDR_REF_CLK_SEL: refSel_nxt = pwdata[7:0];
        ADDR_CTRL_STATUS: ctrl_nxt = pwdata[7:0];
        ADDR_IRQ_ENABLE:  ieReg_nxt = pwdata[7:0];
        ADDR_IRQ_MASK:    mask_nxt = pwdata[ST_WIDTH-1:0];
        default:          ctrl_nxt = ctrl_r;
      endcase
    end
    if (accessR && pready && (addrW == ADDR_IRQ_STATUS)) begin
      status_nxt = '0;
    end
    // hardware set wins over software clear
    if (eventHit) begin
      ctrl_nxt[FLAG_BIT]   = 1'b1;
      status_nxt[ST_EVENT] = 1'b1;
    end
    if (debMiss) begin
      status_nxt[ST_DEB_MISS] = 1'b1;
    end
    irqOut_nxt = |(status_nxt & mask_nxt);
    cmpIrq_nxt = ctrl_nxt[FLAG_BIT] && ieReg_nxt[IE_CMP_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      refSel_r  <= REF_RESET;
      ctrl_r    <= CTRL_RESET;
      ieReg_r   <= IE_RESET;
      status_r  <= '0;
      mask_r    <= '0;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      sample_r  <= 1'b0;
      agree_r   <= 3'h0;
      stable_r  <= 1'b0;
      dbState_r <= DB_IDLE;
      ovfCnt_r  <= 2'h0;
      expect_r  <= 1'b0;
      cmpOut_r  <= 1'b0;
      irqOut_r  <= 1'b0;
      cmpIrq_r  <= 1'b0;
    end else begin
      refSel_r  <= refSel_nxt;
      ctrl_r    <= ctrl_nxt;
      ieReg_r   <= ieReg_nxt;
      status_r  <= status_nxt;
      mask_r    <= mask_nxt;
      prdata    <= prdata_nxt;
      pready    <= pready_nxt;
      pslverr   <= pslverr_nxt;
      sample_r  <= sample_nxt;
      agree_r   <= agree_nxt;
      stable_r  <= stable_nxt;
      dbState_r <= dbState_nxt;
      ovfCnt_r  <= ovfCnt_nxt;
      expect_r  <= expect_nxt;
      cmpOut_r  <= cmpOut_nxt;
      irqOut_r  <= irqOut_nxt;
      cmpIrq_r  <= cmpIrq_nxt;
    end
  end

  // pin-facing controls taken straight from flops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cmpBPinConnect      <= 1'b0;
      cmpBPositiveSelect  <= 2'h0;
      cmpBNegativeSelect  <= 2'h0;
      cmpANegativeSelect  <= 2'h0;
      cmpAClockSelect     <= 2'h0;
      analogPinsInputOnly <= 1'b0;
    end else begin
      cmpBPinConnect      <= ctrl_nxt[CONNECT_BIT];
      cmpBPositiveSelect  <= ctrl_nxt[POS_SEL_LSB +: 2];
      cmpBNegativeSelect  <= refSel_nxt[B_NEG_LSB +: 2];
      cmpANegativeSelect  <= refSel_nxt[A_NEG_LSB +: 2];
      cmpAClockSelect     <= refSel_nxt[A_CLK_LSB +: 2];
      analogPinsInputOnly <= ctrl_nxt[ENABLE_BIT];
    end
  end

  assign cmpBOut = cmpOut_r;
  assign irq     = irqOut_r;
  assign cmpBIrq = cmpIrq_r;
endmodule
`default_nettype wire

// ==== comparator_event_control_assertions.sv ====
/*
  port checker for comparator_event_control, bound to the top module.
  assumes an apb write lands at the edge where pready is sampled high.
*/
`timescale 1ns/1ps
`default_nettype none
module comparator_event_control_assertions
  import cmp_b_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  cmpBRaw,
  input wire logic                  tmr0Ovf,
  input wire logic                  tmr1Ovf,
  input wire logic                  tmr2Ovf,
  input wire logic                  cmpBOut,
  input wire logic                  cmpBPinConnect,
  input wire logic [1:0]            cmpBPositiveSelect,
  input wire logic [1:0]            cmpBNegativeSelect,
  input wire logic [1:0]            cmpANegativeSelect,
  input wire logic [1:0]            cmpAClockSelect,
  input wire logic                  analogPinsInputOnly,
  input wire logic                  cmpBIrq,
  input wire logic                  irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic done;
  logic wrCtrl;
  logic wrRef;
  logic wrIe;
  assign done   = psel && penable && pready && pwrite;
  assign wrCtrl = done && paddr == ADDR_WIDTH'(ADDR_CTRL_STATUS);
  assign wrRef  = done && paddr == ADDR_WIDTH'(ADDR_REF_CLK_SEL);
  assign wrIe   = done && paddr == ADDR_WIDTH'(ADDR_IRQ_ENABLE);
  chk_connect_bit: assert property (wrCtrl |=> cmpBPinConnect == $past(pwdata[CONNECT_BIT]))
    else $error("connect output differs from written bit");
  chk_pos_select: assert property (wrCtrl |=> cmpBPositiveSelect == $past(pwdata[7:6]))
    else $error("positive select differs from written code");
  chk_input_only: assert property (wrCtrl |=> analogPinsInputOnly == $past(pwdata[ENABLE_BIT]))
    else $error("input-only output differs from enable bit");
  chk_out_forced: assert property (!analogPinsInputOnly && !wrCtrl |=> !cmpBOut)
    else $error("comparator output high while disabled");
  chk_out_follows: assert property (analogPinsInputOnly && !wrCtrl |=> cmpBOut == $past(cmpBRaw))
    else $error("comparator output not one cycle behind raw");
  chk_irq_gate: assert property (wrIe && !pwdata[IE_CMP_BIT] |-> ##2 !cmpBIrq)
    else $error("comparator interrupt passed while disabled");
  chk_neg_select: assert property (wrRef |=> {cmpBNegativeSelect, cmpANegativeSelect} ==
                                   {$past(pwdata[5:4]), $past(pwdata[1:0])})
    else $error("negative selects differ from written fields");
  chk_a_clock: assert property (wrRef |=> cmpAClockSelect == $past(pwdata[3:2]))
    else $error("comparator a clock select differs from written field");
  cover property (wrCtrl && pwdata[ENABLE_BIT]);
  cover property ($rose(cmpBIrq));
  cover property ($fell(irq));
endmodule
bind comparator_event_control comparator_event_control_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmpBRaw(cmpBRaw), .tmr0Ovf(tmr0Ovf), .tmr1Ovf(tmr1Ovf), .tmr2Ovf(tmr2Ovf), .cmpBOut(cmpBOut),
  .cmpBPinConnect(cmpBPinConnect), .cmpBPositiveSelect(cmpBPositiveSelect),
  .cmpBNegativeSelect(cmpBNegativeSelect), .cmpANegativeSelect(cmpANegativeSelect),
  .cmpAClockSelect(cmpAClockSelect), .analogPinsInputOnly(analogPinsInputOnly),
  .cmpBIrq(cmpBIrq), .irq(irq));
`default_nettype wire

// ==== cmp_far_model.sv ====
/*
  far side: comparator b output and free-running timer overflow pulses.
  assumes the bench moves the comparator level just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cmp_far_model #(
  parameter int T0 = 4,
  parameter int T1 = 8,
  parameter int T2 = 16
) (
  input  wire logic clk_sys,
  input  wire logic cmpLevel,
  output wire logic cmpBRaw,
  output var  logic tmr0Ovf,
  output var  logic tmr1Ovf,
  output var  logic tmr2Ovf
);
  int cnt = 0;
  assign cmpBRaw = cmpLevel;
  // timers run free, so overflow phase is unrelated to comparator edges
  always @(posedge clk_sys) begin
    cnt     <= cnt + 1;
    tmr0Ovf <= (cnt % T0) == 0;
    tmr1Ovf <= (cnt % T1) == T1 - 1; // kept running for debounced modes
    tmr2Ovf <= (cnt % T2) == 3;
  end
endmodule
`default_nettype wire

// ==== test_comparator_event_control.sv ====
/*
  self-checking bench for comparator_event_control.
  assumes the far-side model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_comparator_event_control;
  import cmp_b_pkg::*;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmpLevel = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, ctl, rng = 32'd46970;
  logic        pready, pslverr, cmpBRaw, tmr0Ovf, tmr1Ovf, tmr2Ovf, cmpBOut, cmpBPinConnect;
  logic        analogPinsInputOnly, cmpBIrq, irq, expBit;
  logic [1:0]  cmpBPositiveSelect, cmpBNegativeSelect, cmpANegativeSelect, cmpAClockSelect;
  logic [32:0] expQ[$], note;
  int          err_count = 0, total_checks = 0, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  comparator_event_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmpBRaw(cmpBRaw), .tmr0Ovf(tmr0Ovf), .tmr1Ovf(tmr1Ovf), .tmr2Ovf(tmr2Ovf), .cmpBOut(cmpBOut),
    .cmpBPinConnect(cmpBPinConnect), .cmpBPositiveSelect(cmpBPositiveSelect),
    .cmpBNegativeSelect(cmpBNegativeSelect), .cmpANegativeSelect(cmpANegativeSelect),
    .cmpAClockSelect(cmpAClockSelect), .analogPinsInputOnly(analogPinsInputOnly), .cmpBIrq(cmpBIrq), .irq(irq));
  cmp_far_model far_u (.clk_sys(clk_sys), .cmpLevel(cmpLevel), .cmpBRaw(cmpBRaw), .tmr0Ovf(tmr0Ovf),
    .tmr1Ovf(tmr1Ovf), .tmr2Ovf(tmr2Ovf));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one transfer, then an idle edge so psel is never set twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] exp);
    expQ.push_back(exp);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b0, 32'h0, {1'b0, d});
  endtask
  // the watcher takes the oldest note whenever an answer appears
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      err_count++;
      stop_test();
    end
    if (pready === 1'b1 && psel === 1'b1) begin
      note = expQ.pop_front();
      if (pwrite) check("pslverr", {32'h0, pslverr}, {32'h0, note[32]});
      else check("read", {pslverr, prdata}, note);
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(ADDR_REF_CLK_SEL, 32'(REF_RESET));
    rd(ADDR_CTRL_STATUS, 32'(CTRL_RESET));
    rd(ADDR_IRQ_ENABLE, 32'(IE_RESET));
    apb(12'h004, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(12'h008, 1'b1, 32'hff, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) begin
      rng = xorshift(rng);
      wr(ADDR_REF_CLK_SEL, rng);
      rd(ADDR_REF_CLK_SEL, {24'h0, rng[7:0]});
      check("refSel", 33'({cmpBNegativeSelect, cmpAClockSelect, cmpANegativeSelect}), 33'(rng[5:0]));
    end
    wr(ADDR_REF_CLK_SEL, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL_STATUS, 32'(c) << POS_SEL_LSB);
      check("posSel", 33'(cmpBPositiveSelect), 33'(c));
    end
    wr(ADDR_IRQ_ENABLE, 32'h40);
    wr(ADDR_IRQ_MASK, 32'h1);
    // every mode, falling then rising; select kept at 3 since connect is set
    for (int m = 0; m < 16; m++) begin
      ctl = 32'he8 | 32'(m[2:0]);
      cmpLevel <= ~m[3];
      wr(ADDR_CTRL_STATUS, ctl);
      repeat (20) @(posedge clk_sys);
      wr(ADDR_CTRL_STATUS, ctl);
      cmpLevel <= m[3];
      repeat (40) @(posedge clk_sys);
      expBit = (m[2:0] == 1 || m[2:0] == 3) ? m[3] : (m[2:0] == 4 || m[2:0] == 6) ? ~m[3] : 1'b1;
      rd(ADDR_CTRL_STATUS, ctl | (32'(expBit) << FLAG_BIT));
      check("cmpBIrq", 33'(cmpBIrq), 33'(expBit));
      check("pins", 33'({cmpBPinConnect, analogPinsInputOnly}), 33'h3);
    end
    wr(ADDR_IRQ_ENABLE, 32'h0);
    check("cmpBIrq", 33'(cmpBIrq), 33'h0);
    wr(ADDR_CTRL_STATUS, 32'h07);
    wr(ADDR_CTRL_STATUS, 32'h07);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_CTRL_STATUS, 32'h07);
    check("irq", 33'(irq), 33'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    check("irq", 33'(irq), 33'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk_sys);
    check("irq", 33'(irq), 33'h0);
    cmpLevel <= 1'b0;
    wr(ADDR_CTRL_STATUS, 32'h0b);
    repeat (20) @(posedge clk_sys);
    rd(ADDR_IRQ_STATUS, 32'h0);
    cmpLevel <= 1'b1;
    @(posedge clk_sys);
    cmpLevel <= 1'b0;
    repeat (30) @(posedge clk_sys);
    rd(ADDR_IRQ_STATUS, 32'h2);
    rd(ADDR_CTRL_STATUS, 32'h0b);
    // connect is clear here, so the selects may change
    wr(ADDR_REF_CLK_SEL, 32'h40);
    wr(ADDR_CTRL_STATUS, 32'h29);
    repeat (20) @(posedge clk_sys);
    wr(ADDR_CTRL_STATUS, 32'h29);
    cmpLevel <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cmpLevel <= 1'b0;
    repeat (40) @(posedge clk_sys);
    rd(ADDR_CTRL_STATUS, 32'h29);
    cmpLevel <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check("cmpBOut", 33'(cmpBOut), 33'h1);
    rd(ADDR_CTRL_STATUS, 32'h39);
    stop_test();
  end
endmodule
`default_nettype wire
